// ==== sim/cfg_store_model.sv ====
// configuration ram model taking the flash copy
`timescale 1ns/100ps
module cfg_store_model
#(
    parameter int CFG_WORDS = 4
)
(
    input wire logic                         ref_clk,
    input wire logic                         nrst,
    input wire logic                         copy_active,
    input wire logic                         copy_we,
    input wire logic [$clog2(CFG_WORDS)-1:0] copy_addr,
    output int                               words_written,
    output logic                             order_bad
);
    int next_addr;

    // ram is overwritten whatever flash holds, so every word counts
    always @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            words_written <= 0;
            order_bad     <= 1'b0;
            next_addr     <= 0;
        end
        else if (copy_we === 1'b1)
        begin
            words_written <= words_written + 1;
            next_addr     <= next_addr + 1;
            if (int'(copy_addr) != next_addr)
                order_bad <= 1'b1;
        end
        else if (copy_active !== 1'b1)
            next_addr <= 0;
    end
endmodule

// ==== sim/start_mode_sequencer_bench.sv ====
// self-checking bench of the start mode sequencer
`timescale 1ns/100ps
module start_mode_sequencer_bench;
import seq_pkg::*;
    localparam int S = 20, E = 5, W = 4;
    typedef struct packed { logic sw; logic [1:0] sel; logic clean; } row_type;
    logic                 ref_clk, nrst, flash_boot_pin, restart_pin, copy_active, copy_we;
    logic [$clog2(W)-1:0] copy_addr;
    avm_req_type          avm_req;
    avm_rsp_type          avm_rsp;
    unit_ctl_type         unit_ctl;
    logic                 order_bad;
    int                   words_written, err_total, compares, cycles, clr_cnt, exch_cnt, stat_cnt;
    int                   c0, e0, w0;
    logic [31:0]          q;
    row_type              rows [4] = '{'{1'b0, 2'h1, 1'b0}, '{1'b0, 2'h2, 1'b1},
                                      '{1'b0, 2'h3, 1'b0}, '{1'b1, 2'h1, 1'b1}};

    start_mode_sequencer #(.STATUS_CYCLES(S), .EXEC_CYCLES(E), .CFG_WORDS(W))
    start_mode_sequencer_inst (.ref_clk(ref_clk), .nrst(nrst), .avm_req(avm_req),
        .avm_rsp(avm_rsp), .flash_boot_pin(flash_boot_pin), .restart_pin(restart_pin),
        .copy_active(copy_active), .copy_we(copy_we), .copy_addr(copy_addr),
        .unit_ctl(unit_ctl));
    cfg_store_model #(.CFG_WORDS(W)) cfg_store_model_inst (.ref_clk(ref_clk), .nrst(nrst),
        .copy_active(copy_active), .copy_we(copy_we), .copy_addr(copy_addr),
        .words_written(words_written), .order_bad(order_bad));

    // ------------------------------------------------------------
    // clock, pulse counters, timeout
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (unit_ctl.mem_clear === 1'b1) clr_cnt++;
        if (unit_ctl.exchange_strobe === 1'b1) exch_cnt++;
        if (unit_ctl.status_strobe === 1'b1) stat_cnt++;
        if (cycles == 20000)
        begin
            err_total++;
            test_done();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low, then an idle cycle
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        avm_req <= '{read: !wr, write: wr, address: a, writedata: d};
        @(posedge ref_clk);
        while (avm_rsp.waitrequest !== 1'b0) @(posedge ref_clk);
        q = avm_rsp.readdata;
        avm_req <= '0;
        @(posedge ref_clk);
    endtask

    task automatic wait_run();
        repeat (3) @(posedge ref_clk);
        while (!(unit_ctl.exec_enable === 1'b1 && copy_active === 1'b0)) @(posedge ref_clk);
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {nrst, flash_boot_pin, restart_pin, avm_req} = '0;
        {err_total, compares, cycles, clr_cnt, exch_cnt, stat_cnt} = '0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        bus(1'b0, OFS_CONFIG, 32'h0);
        check("config reset", 32'h1, q);
        bus(1'b0, OFS_COMMAND, 32'h0);
        check("command reset", 32'h0, q);
        foreach (rows[i])
        begin
            flash_boot_pin <= rows[i].sw;
            bus(1'b1, OFS_CONFIG, {30'h0, rows[i].sel});
            c0 = clr_cnt;
            w0 = words_written;
            restart_pin <= 1'b1;
            repeat (4) @(posedge ref_clk);
            restart_pin <= 1'b0;
            wait_run();
            bus(1'b0, OFS_STATUS, 32'h0);
            check("state", 32'h3, {29'h0, q[2:0]});
            check("clean", {31'h0, rows[i].clean}, {31'h0, q[6]});
            check("clears", {31'h0, rows[i].clean}, clr_cnt - c0);
            check("copied", rows[i].sw ? W : 0, words_written - w0);
            check("order", 32'h0, {31'h0, order_bad});
        end
        flash_boot_pin <= 1'b0;
        bus(1'b1, OFS_COMMAND, 32'h100);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("load stop", 32'h4, {28'h0, q[3:0]});
        e0 = exch_cnt;
        c0 = stat_cnt;
        repeat (25) @(posedge ref_clk);
        check("exch stopped", 32'h0, exch_cnt - e0);
        check("status stopped", 32'h1, {31'h0, stat_cnt > c0});
        bus(1'b1, OFS_COMMAND, 32'h3);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("code3", 32'h4, {29'h0, q[2:0]});
        c0 = clr_cnt;
        bus(1'b1, OFS_COMMAND, 32'h1);
        wait_run();
        bus(1'b0, OFS_STATUS, 32'h0);
        check("warm", 32'hb, {25'h0, q[6:0]} & 32'h4f);
        check("warm clears", 32'h0, clr_cnt - c0);
        check("led", 32'h1, {31'h0, unit_ctl.run_led});
        e0 = exch_cnt;
        repeat (22) @(posedge ref_clk);
        check("exch run", 32'h1, {31'h0, (exch_cnt - e0 == 4) || (exch_cnt - e0 == 5)});
        bus(1'b1, OFS_COMMAND, 32'h2);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("reject", 32'h23, {26'h0, q[5:0]} & 32'h27);
        bus(1'b1, OFS_STATUS, 32'h20);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("reject clr", 32'h0, {31'h0, q[5]});
        bus(1'b1, OFS_COMMAND, 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        check("stop", 32'h4, {29'h0, q[2:0]});
        c0 = clr_cnt;
        bus(1'b1, OFS_COMMAND, 32'h2);
        wait_run();
        bus(1'b0, OFS_STATUS, 32'h0);
        check("cold", 32'h1, {31'h0, q[6]});
        check("cold clears", 32'h1, clr_cnt - c0);
        bus(1'b0, 4'hc, 32'h0);
        check("unmapped", 32'h0, q);
        bus(1'b1, OFS_COMMAND, 32'h100);
        c0 = clr_cnt;
        nrst           <= 1'b0;
        flash_boot_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        wait_run();
        bus(1'b0, OFS_STATUS, 32'h0);
        check("power cycle", 32'h3, {29'h0, q[2:0]});
        check("power clean", 32'h1, {31'h0, q[6]});
        check("power copied", W, words_written);
        check("power order", 32'h0, {31'h0, order_bad});
        check("power clears", 32'h1, clr_cnt - c0);
        test_done();
    end
endmodule

bind start_mode_sequencer start_mode_sequencer_monitor #(.STATUS_CYCLES(STATUS_CYCLES),
    .EXEC_CYCLES(EXEC_CYCLES), .CFG_WORDS(CFG_WORDS))
start_mode_sequencer_monitor_inst (.ref_clk(ref_clk), .nrst(nrst), .avm_req(avm_req),
    .avm_rsp(avm_rsp), .flash_boot_pin(flash_boot_pin), .restart_pin(restart_pin),
    .copy_active(copy_active), .copy_we(copy_we), .copy_addr(copy_addr),
    .unit_ctl(unit_ctl));

// ==== sim/start_mode_sequencer_monitor.sv ====
// assertion checker for the start mode sequencer ports
`timescale 1ns/100ps
module start_mode_sequencer_monitor
import seq_pkg::*;
#(
    parameter int STATUS_CYCLES = 20,
    parameter int EXEC_CYCLES   = 5,
    parameter int CFG_WORDS     = 4
)
(
    input wire logic                         ref_clk,
    input wire logic                         nrst,
    input wire seq_pkg::avm_req_type         avm_req,
    input wire seq_pkg::avm_rsp_type         avm_rsp,
    input wire logic                         flash_boot_pin,
    input wire logic                         restart_pin,
    input wire logic                         copy_active,
    input wire logic                         copy_we,
    input wire logic [$clog2(CFG_WORDS)-1:0] copy_addr,
    input wire seq_pkg::unit_ctl_type        unit_ctl
);
    int   gap_reg, gap_next, words_reg, words_next;
    logic seen_reg, seen_next;

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    always_comb
    begin
        gap_next   = unit_ctl.status_strobe ? 0 : gap_reg + 1;
        seen_next  = seen_reg | unit_ctl.status_strobe;
        words_next = copy_active ? words_reg + int'(copy_we) : 0;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gap_reg   <= 0;
            seen_reg  <= 1'b0;
            words_reg <= 0;
        end
        else
        begin
            gap_reg   <= gap_next;
            seen_reg  <= seen_next;
            words_reg <= words_next;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_led; unit_ctl.run_led == unit_ctl.exec_enable; endproperty
    a_led: assert property (p_led) else $error("run led differs from running");
    property p_clear_pair; unit_ctl.mem_clear |-> unit_ctl.loops_manual; endproperty
    a_clear_pair: assert property (p_clear_pair) else $error("clear without manual");
    property p_clear_pulse; unit_ctl.mem_clear |=> !unit_ctl.mem_clear; endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");
    property p_clear_run; unit_ctl.mem_clear |-> ##[0:2] unit_ctl.exec_enable; endproperty
    a_clear_run: assert property (p_clear_run) else $error("no run after clear");
    property p_exch; unit_ctl.exchange_strobe |-> unit_ctl.exec_enable; endproperty
    a_exch: assert property (p_exch) else $error("exchange while stopped");
    property p_copy_we; copy_we |-> copy_active; endproperty
    a_copy_we: assert property (p_copy_we) else $error("copy write outside copy");
    property p_copy_len; $fell(copy_active) |-> words_reg == CFG_WORDS; endproperty
    a_copy_len: assert property (p_copy_len) else $error("copy word count wrong");
    property p_status_gap;
        seen_reg |-> gap_reg < STATUS_CYCLES &&
            (!unit_ctl.status_strobe || gap_reg == STATUS_CYCLES - 1);
    endproperty
    a_status_gap: assert property (p_status_gap) else $error("status period wrong");
    property p_wait;
        (avm_req.read || avm_req.write) && avm_rsp.waitrequest |=> !avm_rsp.waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
endmodule

// ==== src/seq_pkg.sv ====
// constants, register map and carrier types of the start mode sequencer
package seq_pkg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    localparam int          ADDR_W      = 4;
    localparam int          DATA_W      = 32;
    localparam logic [3:0]  OFS_CONFIG  = 4'h0;
    localparam logic [3:0]  OFS_COMMAND = 4'h4;
    localparam logic [3:0]  OFS_STATUS  = 4'h8;

    // field positions
    localparam int CODE_LSB    = 0;
    localparam int CODE_W      = 2;
    localparam int LOAD_BIT    = 8;
    localparam int ST_STATE_LSB = 0;
    localparam int ST_RUN_BIT  = 3;
    localparam int ST_SW_BIT   = 4;
    localparam int ST_REJ_BIT  = 5;
    localparam int ST_COLD_BIT = 6;
    localparam int ST_COPY_BIT = 7;

    // start selection and command codes
    localparam logic [1:0] SEL_WARM  = 2'h1;
    localparam logic [1:0] SEL_COLD  = 2'h2;
    localparam logic [1:0] SEL_RESET = SEL_WARM;
    localparam logic [1:0] CMD_STOP  = 2'h0;
    localparam logic [1:0] CMD_WARM  = 2'h1;
    localparam logic [1:0] CMD_COLD  = 2'h2;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ          = 10_000_000;
    localparam int STATUS_PERIOD_S = 1;
    localparam int STATUS_CYCLES   = CLK_HZ * STATUS_PERIOD_S;
    localparam int EXEC_CYCLES     = 1_000_000;
    localparam int CFG_WORDS       = 256;

    typedef enum logic [2:0] {
        ST_BOOT = 3'b000,
        ST_COPY = 3'b001,
        ST_INIT = 3'b010,
        ST_RUN  = 3'b011,
        ST_STOP = 3'b100
    } seq_state_type;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } avm_req_type;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              waitrequest;
    } avm_rsp_type;

    typedef struct packed {
        logic exec_enable;
        logic exchange_strobe;
        logic status_strobe;
        logic mem_clear;
        logic loops_manual;
        logic run_led;
    } unit_ctl_type;

endpackage

// ==== src/start_mode_sequencer.sv ====
// start mode sequencer: chooses warm or clean start and drives the unit
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module start_mode_sequencer
#(
    parameter int STATUS_CYCLES = seq_pkg::STATUS_CYCLES,
    parameter int EXEC_CYCLES   = seq_pkg::EXEC_CYCLES,
    parameter int CFG_WORDS     = seq_pkg::CFG_WORDS
)
(
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire seq_pkg::avm_req_type avm_req,
    output seq_pkg::avm_rsp_type      avm_rsp,
    input  wire logic                 flash_boot_pin,
    input  wire logic                 restart_pin,
    output logic                      copy_active,
    output logic                      copy_we,
    output logic [$clog2(CFG_WORDS)-1:0] copy_addr,
    output seq_pkg::unit_ctl_type     unit_ctl
);
    import seq_pkg::*;

    localparam int CW = $clog2(CFG_WORDS);
    localparam int SW = $clog2(STATUS_CYCLES + 1);
    localparam int EW = $clog2(EXEC_CYCLES + 1);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] sw_sync_reg, sw_sync_next;
    logic [1:0] rst_sync_reg, rst_sync_next;
    logic [1:0] primed_reg, primed_next;
    logic       restart_old_reg, restart_old_next;
    logic       restart_rise, switch_on;

    always_comb
    begin
        sw_sync_next     = {sw_sync_reg[0], flash_boot_pin};
        rst_sync_next    = {rst_sync_reg[0], restart_pin};
        restart_old_next = rst_sync_reg[1];
        primed_next      = {primed_reg[0], 1'b1};
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sw_sync_reg     <= 2'h0;
            rst_sync_reg    <= 2'h0;
            restart_old_reg <= 1'b0;
            primed_reg      <= 2'h0;
        end
        else
        begin
            sw_sync_reg     <= sw_sync_next;
            rst_sync_reg    <= rst_sync_next;
            restart_old_reg <= restart_old_next;
            primed_reg      <= primed_next;
        end
    end

    assign switch_on    = sw_sync_reg[1];
    assign restart_rise = rst_sync_reg[1] & ~restart_old_reg;

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    logic [1:0]    select_reg, select_next;
    logic [1:0]    last_cmd_reg, last_cmd_next;
    logic          reject_reg, reject_next;
    avm_rsp_type   rsp_reg, rsp_next;
    logic          wr_take, cmd_wr, load_evt, start_evt;
    logic [1:0]    wr_code;
    seq_state_type state_reg, state_next;
    logic          cold_reg, cold_next;
    logic [CW-1:0] copy_cnt_reg, copy_cnt_next;

    // a write lands at the edge where waitrequest is seen low
    assign wr_take   = avm_req.write & ~rsp_reg.waitrequest;
    assign wr_code   = avm_req.writedata[CODE_LSB +: CODE_W];
    assign cmd_wr    = wr_take & (avm_req.address == OFS_COMMAND);
    assign load_evt  = cmd_wr & avm_req.writedata[LOAD_BIT];
    assign start_evt = cmd_wr & ~avm_req.writedata[LOAD_BIT]
                       & ((wr_code == CMD_WARM) | (wr_code == CMD_COLD));

    always_comb
    begin
        select_next   = select_reg;
        last_cmd_next = last_cmd_reg;
        reject_next   = reject_reg;
        rsp_next      = rsp_reg;
        // one wait cycle per access, then ready for exactly one edge
        rsp_next.waitrequest = ~((avm_req.read | avm_req.write) & rsp_reg.waitrequest);
        if ((avm_req.read | avm_req.write) & rsp_reg.waitrequest)
        begin
            rsp_next.readdata = '0;
            if (avm_req.address == OFS_CONFIG)
            begin
                rsp_next.readdata[CODE_LSB +: CODE_W] = select_reg;
            end
            else if (avm_req.address == OFS_COMMAND)
            begin
                rsp_next.readdata[CODE_LSB +: CODE_W] = last_cmd_reg;
            end
            else if (avm_req.address == OFS_STATUS)
            begin
                rsp_next.readdata[ST_STATE_LSB +: $bits(seq_state_type)] = state_reg;
                rsp_next.readdata[ST_RUN_BIT]  = (state_reg == ST_RUN);
                rsp_next.readdata[ST_SW_BIT]   = switch_on;
                rsp_next.readdata[ST_REJ_BIT]  = reject_reg;
                rsp_next.readdata[ST_COLD_BIT] = cold_reg;
                rsp_next.readdata[ST_COPY_BIT] = (state_reg == ST_COPY);
            end
        end
        if (wr_take & (avm_req.address == OFS_CONFIG))
        begin
            select_next = wr_code;
        end
        if (cmd_wr & ~avm_req.writedata[LOAD_BIT])
        begin
            last_cmd_next = wr_code;
        end
        if (wr_take & (avm_req.address == OFS_STATUS) & avm_req.writedata[ST_REJ_BIT])
        begin
            reject_next = 1'b0;
        end
        // set beats clear in the same cycle
        if (start_evt & (state_reg == ST_RUN))
        begin
            reject_next = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            select_reg       <= SEL_RESET;
            last_cmd_reg     <= CMD_STOP;
            reject_reg       <= 1'b0;
            rsp_reg          <= '{readdata: '0, waitrequest: 1'b1};
        end
        else
        begin
            select_reg   <= select_next;
            last_cmd_reg <= last_cmd_next;
            reject_reg   <= reject_next;
            rsp_reg      <= rsp_next;
        end
    end

    // ----------------------------------------------------------------
    // start sequence
    // ----------------------------------------------------------------
    always_comb
    begin
        state_next    = state_reg;
        cold_next     = cold_reg;
        copy_cnt_next = copy_cnt_reg;
        case (state_reg)
            ST_BOOT:
            begin
                copy_cnt_next = '0;
                if (!primed_reg[1])
                begin
                    // synchroniser still shows its reset level, not the switch
                    state_next = ST_BOOT;
                end
                else if (switch_on)
                begin
                    state_next = ST_COPY;
                    cold_next  = 1'b1;
                end
                else if (select_reg == SEL_COLD)
                begin
                    state_next = ST_INIT;
                    cold_next  = 1'b1;
                end
                else
                begin
                    // unknown codes fall back to the warm default
                    state_next = ST_RUN;
                    cold_next  = 1'b0;
                end
            end
            ST_COPY:
            begin
                // no check of flash contents: empty flash still wipes RAM
                copy_cnt_next = copy_cnt_reg + 1'b1;
                if (copy_cnt_reg == CW'(CFG_WORDS - 1))
                begin
                    state_next = ST_INIT;
                end
            end
            ST_INIT:
            begin
                state_next = ST_RUN;
            end
            ST_RUN:
            begin
                // host operating mode has no input here by design
                if (cmd_wr & ~avm_req.writedata[LOAD_BIT] & (wr_code == CMD_STOP))
                begin
                    state_next = ST_STOP;
                end
            end
            ST_STOP:
            begin
                if (start_evt)
                begin
                    state_next = (wr_code == CMD_COLD) ? ST_INIT : ST_RUN;
                    cold_next  = (wr_code == CMD_COLD);
                end
            end
            default:
            begin
                state_next = ST_BOOT;
            end
        endcase
        if (load_evt)
        begin
            state_next = ST_STOP;
        end
        if (restart_rise)
        begin
            state_next = ST_BOOT;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_reg    <= ST_BOOT;
            cold_reg     <= 1'b0;
            copy_cnt_reg <= '0;
        end
        else
        begin
            state_reg    <= state_next;
            cold_reg     <= cold_next;
            copy_cnt_reg <= copy_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // timers and unit controls
    // ----------------------------------------------------------------
    logic [SW-1:0] stat_cnt_reg, stat_cnt_next;
    logic [EW-1:0] exec_cnt_reg, exec_cnt_next;
    unit_ctl_type  ctl_reg, ctl_next;
    logic          copy_we_reg, copy_we_next;
    logic [CW-1:0] copy_addr_reg, copy_addr_next;
    logic          copy_act_reg, copy_act_next;
    logic          running;
    assign running = (state_reg == ST_RUN);

    always_comb
    begin
        stat_cnt_next = stat_cnt_reg + 1'b1;
        ctl_next      = '0;
        if (stat_cnt_reg == SW'(STATUS_CYCLES - 1))
        begin
            stat_cnt_next = '0;
            ctl_next.status_strobe = 1'b1;
        end
        exec_cnt_next = '0;
        if (running)
        begin
            exec_cnt_next = exec_cnt_reg + 1'b1;
            if (exec_cnt_reg == EW'(EXEC_CYCLES - 1))
            begin
                exec_cnt_next = '0;
                ctl_next.exchange_strobe = 1'b1;
            end
        end
        ctl_next.exec_enable  = running;
        ctl_next.run_led      = running;
        // set points and tuning are outside the cleared area
        ctl_next.mem_clear    = (state_reg == ST_INIT);
        ctl_next.loops_manual = (state_reg == ST_INIT);
        copy_act_next  = (state_reg == ST_COPY);
        copy_we_next   = (state_reg == ST_COPY);
        copy_addr_next = copy_cnt_reg;
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            stat_cnt_reg  <= '0;
            exec_cnt_reg  <= '0;
            ctl_reg       <= '0;
            copy_act_reg  <= 1'b0;
            copy_we_reg   <= 1'b0;
            copy_addr_reg <= '0;
        end
        else
        begin
            stat_cnt_reg  <= stat_cnt_next;
            exec_cnt_reg  <= exec_cnt_next;
            ctl_reg       <= ctl_next;
            copy_act_reg  <= copy_act_next;
            copy_we_reg   <= copy_we_next;
            copy_addr_reg <= copy_addr_next;
        end
    end

    assign avm_rsp     = rsp_reg;
    assign unit_ctl    = ctl_reg;
    assign copy_active = copy_act_reg;
    assign copy_we     = copy_we_reg;
    assign copy_addr   = copy_addr_reg;

endmodule
